// ==== core/touch_i2c_regs.svh ====
// Constants for the two-wire slave port: address, framing and timing
`ifndef TOUCH_I2C_REGS_SVH
`define TOUCH_I2C_REGS_SVH

`define SLAVE_ADDR      7'h41
`define BITS_PER_BYTE   4'h8
`define ACK_BIT_INDEX   4'h8
`define DIR_READ        1'b1
`define DIR_WRITE       1'b0
`define REG_ADDR_LAST   8'hFF
`define REG_ADDR_FIRST  8'h00
`define CLK_PERIOD_NS   4
// One clock of hold after the seen SCL fall; a longer hold would overrun a short SCL low phase
`define HOLD_TIME_NS    4
`define HOLD_CYCLES     (((`HOLD_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// ==== core/touch_i2c_pkg.sv ====
// Types shared by the two-wire slave port modules
package touch_i2c_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDRACK = 3'b010,
    ST_RXBYTE  = 3'b011,
    ST_RXACK   = 3'b100,
    ST_TXBYTE  = 3'b101,
    ST_TXACK   = 3'b110,
    ST_IGNORE  = 3'b111
  } slave_state_t;

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic       sclPrev;
    logic       sdaPrev;
    logic       sclRise;
    logic       sclFall;
    logic       startSeen;
    logic       stopSeen;
    logic       sclLevel;
    logic       sdaLevel;
  } line_state_t;

endpackage

// ==== core/bus_line_if.sv ====
// Conditioned bus line events passed from the line sampler to the slave engine
`timescale 1ns/1ps
`default_nettype none
interface bus_line_if;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaLevel;

  modport producer (output sclRise, output sclFall, output startSeen, output stopSeen, output sdaLevel);
  modport consumer (input sclRise, input sclFall, input startSeen, input stopSeen, input sdaLevel);
endinterface
`default_nettype wire

// ==== core/bus_line_sampler.sv ====
// Two-flop synchronisers and edge, Start and Stop detection for SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module bus_line_sampler
  import touch_i2c_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst,
  // Bus pins
  input  wire logic      sclIn,
  input  wire logic      sdaIn,
  // Events
  bus_line_if.producer   lines
);

  line_state_t st_reg;
  line_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sclSync = {st_reg.sclSync[0], sclIn};
    st_next.sdaSync = {st_reg.sdaSync[0], sdaIn};
    // Only the second flop stage is looked at
    st_next.sclPrev = st_reg.sclSync[1];
    st_next.sdaPrev = st_reg.sdaSync[1];
    st_next.sclLevel = st_reg.sclSync[1];
    st_next.sdaLevel = st_reg.sdaSync[1];
    st_next.sclRise = st_reg.sclSync[1] & ~st_reg.sclPrev;
    st_next.sclFall = ~st_reg.sclSync[1] & st_reg.sclPrev;
    st_next.startSeen = st_reg.sclSync[1] & st_reg.sclPrev & st_reg.sdaPrev & ~st_reg.sdaSync[1];
    st_next.stopSeen = st_reg.sclSync[1] & st_reg.sclPrev & ~st_reg.sdaPrev & st_reg.sdaSync[1];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '{sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1,
                  sclLevel: 1'b1, sdaLevel: 1'b1, default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lines.sclRise   = st_reg.sclRise;
  assign lines.sclFall   = st_reg.sclFall;
  assign lines.startSeen = st_reg.startSeen;
  assign lines.stopSeen  = st_reg.stopSeen;
  assign lines.sdaLevel  = st_reg.sdaLevel;

endmodule
`default_nettype wire

// ==== core/auto_inc_lookup.sv ====
// Decides whether a register address lies in an auto-incrementing range
`timescale 1ns/1ps
`default_nettype none
module auto_inc_lookup (
  // Register address
  input  wire logic [7:0] regAddr,
  // Range boundary supplied by the register map
  input  wire logic [7:0] fixedLow,
  input  wire logic [7:0] fixedHigh,
  // Result
  output logic            autoInc
);

  always_comb begin
    autoInc = !((regAddr >= fixedLow) && (regAddr <= fixedHigh));
  end

endmodule
`default_nettype wire

// ==== core/touch_i2c_slave.sv ====
// Two-wire serial slave port giving a bus master byte access to the register map
// What this block does
// - Start, 7-bit address, direction bit; 1 is read, 0 is write.
// - Own address matched: SDA pulled low in the ninth bit.
// - Address mismatch: no acknowledge, rest of transaction ignored.
// - Own 7-bit address is 0x41, bytes 0x82 write, 0x83 read.
// - Works at 100 and 400 kbit/s clock rates.
// - Start is SDA falling while SCL high.
// - Always watch for Start; ignore everything until one is seen.
// - Stop is SDA rising while SCL high; it ends the transaction.
// - After an unacknowledged read byte and Stop, return to idle.
// - Stop during a write ends writing until a new addressed transaction.
// - Transmitter releases SDA after eight bits; receiver acknowledges low.
// - SDA left high in ninth bit means no acknowledge.
// - Incoming SDA bits sampled on rising SCL.
// - Read: address+write, register address, restart, address+read, data, Stop.
// - Reads continue until Stop, address incrementing in auto ranges.
// - Non-incrementing range keeps the read address fixed.
// - Write: address+write, register address, acknowledged data bytes, Stop.
// - Writes continue until Stop, address advancing in auto ranges.
// - Non-incrementing range keeps the write address fixed.
// - Master no-acknowledge after a read byte ends sending; rest ignored until Stop or Start.
// - Incrementing address wraps past the last register to the first.
`timescale 1ns/1ps
`default_nettype none
`include "touch_i2c_regs.svh"
module touch_i2c_slave
  import touch_i2c_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Bus pins (open drain SDA: enable high pulls low)
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Non-incrementing address range from the register map
  input  wire logic [7:0] fixedLow,
  input  wire logic [7:0] fixedHigh,
  // Register map access
  output logic [7:0]      regAddr,
  output logic [7:0]      wrData,
  output logic            wrStrobe,
  output logic            rdStrobe,
  input  wire logic [7:0] rdData,
  // Status
  output logic            busy
);

  typedef struct packed {
    slave_state_t state;
    logic [3:0]   bitCount;
    logic [7:0]   shift;
    logic         isRead;
    logic         haveAddr;
    logic [7:0]   addr;
    logic [7:0]   wrData;
    logic         wrStrobe;
    logic         rdStrobe;
    logic         sdaOe;
    logic [7:0]   holdCount;
    logic         busy;
  } engine_t;

  engine_t e_reg;
  engine_t e_next;

  bus_line_if lines ();
  logic       autoInc;

  bus_line_sampler u_sampler (
    .clock (clock),
    .rst   (rst),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .lines (lines)
  );

  auto_inc_lookup u_lookup (
    .regAddr   (e_reg.addr),
    .fixedLow  (fixedLow),
    .fixedHigh (fixedHigh),
    .autoInc   (autoInc)
  );

  // Next register address; stays put in a fixed range
  function automatic logic [7:0] bumpAddr(input logic [7:0] a, input logic inc);
    logic [7:0] r;
    r = a;
    if (inc) begin
      r = (a == `REG_ADDR_LAST) ? `REG_ADDR_FIRST : a + 8'h01;
    end
    return r;
  endfunction

  always_comb begin
    e_next = e_reg;
    e_next.wrStrobe = 1'b0;
    e_next.rdStrobe = 1'b0;
    if (e_reg.holdCount != 8'h00) begin
      e_next.holdCount = e_reg.holdCount - 8'h01;
    end
    if (lines.startSeen) begin
      e_next.state    = ST_ADDR;
      e_next.bitCount = 4'h0;
      e_next.sdaOe    = 1'b0;
      e_next.busy     = 1'b1;
      // First byte after a write address is always a register address
      e_next.haveAddr = 1'b0;
    end else if (lines.stopSeen) begin
      e_next.state    = ST_IDLE;
      e_next.sdaOe    = 1'b0;
      e_next.haveAddr = 1'b0;
      e_next.busy     = 1'b0;
    end else begin
      unique case (e_reg.state)
        ST_IDLE, ST_IGNORE: begin
          e_next.sdaOe = 1'b0;
        end
        ST_ADDR, ST_RXBYTE: begin
          if (lines.sclRise) begin
            e_next.shift    = {e_reg.shift[6:0], lines.sdaLevel};
            e_next.bitCount = e_reg.bitCount + 4'h1;
          end
          if (lines.sclFall && e_reg.bitCount == `BITS_PER_BYTE) begin
            e_next.bitCount  = 4'h0;
            e_next.holdCount = 8'(`HOLD_CYCLES);
            if (e_reg.state == ST_ADDR) begin
              if (e_reg.shift[7:1] == `SLAVE_ADDR) begin
                e_next.isRead = (e_reg.shift[0] == `DIR_READ);
                e_next.state  = ST_ADDRACK;
              end else begin
                e_next.state = ST_IGNORE;
              end
            end else begin
              if (!e_reg.haveAddr) begin
                e_next.addr     = e_reg.shift;
                e_next.haveAddr = 1'b1;
              end else begin
                e_next.wrData   = e_reg.shift;
                e_next.wrStrobe = 1'b1;
              end
              e_next.state = ST_RXACK;
            end
          end
        end
        ST_ADDRACK, ST_RXACK: begin
          if (e_reg.holdCount == 8'h01) begin
            e_next.sdaOe = 1'b1;
          end
          if (lines.sclFall && e_reg.sdaOe) begin
            e_next.holdCount = 8'(`HOLD_CYCLES);
            e_next.sdaOe     = 1'b0;
            if (e_reg.state == ST_ADDRACK && e_reg.isRead) begin
              e_next.shift    = rdData;
              e_next.rdStrobe = 1'b1;
              e_next.state    = ST_TXBYTE;
            end else begin
              e_next.state = ST_RXBYTE;
            end
          end
          // Fixed range holds
          // Stepped the cycle after the strobe so the store still sees the old address
          if (e_reg.state == ST_RXACK && e_reg.wrStrobe) begin
            e_next.addr = bumpAddr(e_reg.addr, autoInc);
          end
        end
        ST_TXBYTE: begin
          if (e_reg.holdCount == 8'h01) begin
            e_next.sdaOe = ~e_reg.shift[7];
          end
          if (lines.sclFall) begin
            e_next.holdCount = 8'(`HOLD_CYCLES);
            e_next.bitCount  = e_reg.bitCount + 4'h1;
            e_next.shift     = {e_reg.shift[6:0], 1'b0};
            if (e_reg.bitCount == `BITS_PER_BYTE - 4'h1) begin
              e_next.sdaOe     = 1'b0;
              e_next.holdCount = 8'h00;
              e_next.bitCount  = 4'h0;
              e_next.state     = ST_TXACK;
              e_next.addr = bumpAddr(e_reg.addr, autoInc);
            end
          end
        end
        ST_TXACK: begin
          e_next.sdaOe = 1'b0;
          if (lines.sclRise) begin
            if (lines.sdaLevel) begin
              e_next.state = ST_IGNORE;
            end else begin
              e_next.bitCount = 4'h1;
            end
          end
          // Next byte after acknowledge
          // Loaded when the acknowledge bit ends, once the master has let go of SDA
          if (lines.sclFall && e_reg.bitCount == 4'h1) begin
            e_next.shift     = rdData;
            e_next.rdStrobe  = 1'b1;
            e_next.holdCount = 8'(`HOLD_CYCLES);
            e_next.bitCount  = 4'h0;
            e_next.state     = ST_TXBYTE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      e_reg <= '{state: ST_IDLE, default: '0};
    end else begin
      e_reg <= e_next;
    end
  end

  // Timing margin
  // The 4 ns clock oversamples a 400 kHz SCL about 600 times per period
  assign sdaOut   = 1'b0;
  assign sdaOe    = e_reg.sdaOe;
  assign regAddr  = e_reg.addr;
  assign wrData   = e_reg.wrData;
  assign wrStrobe = e_reg.wrStrobe;
  assign rdStrobe = e_reg.rdStrobe;
  assign busy     = e_reg.busy;

endmodule
`default_nettype wire

// ==== sim/touch_i2c_slave_asserts.sv ====
// Port assertions for the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_slave_asserts (
  // Watched ports
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOe,
  input wire logic [7:0] regAddr,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic       busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  idle_quiet_a: assert property (!busy |-> !sdaOe && !wrStrobe)
    else $error("slave active while idle");
  start_busy_a: assert property ($fell(sdaIn) && sclIn && $past(sclIn) |-> ##[1:8] busy)
    else $error("start not taken");
  stop_idle_a: assert property ($rose(sdaIn) && sclIn && $past(sclIn) |-> ##[1:8] !busy)
    else $error("stop not taken");
  // SCL high a long time, so an SDA move there would fake a Start or Stop
  sda_change_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("slave moved sda while scl high");
  wr_pulse_a: assert property (wrStrobe |=> !wrStrobe)
    else $error("write strobe too long");
  rd_pulse_a: assert property (rdStrobe |=> !rdStrobe)
    else $error("read strobe too long");
  wr_in_frame_a: assert property (wrStrobe |-> busy && !rdStrobe)
    else $error("write outside a frame");
  rd_in_frame_a: assert property (rdStrobe |-> busy)
    else $error("read outside a frame");
  addr_idle_a: assert property (!busy && !$past(busy) |-> $stable(regAddr))
    else $error("address moved while idle");
endmodule

bind touch_i2c_slave touch_i2c_slave_asserts chk (
  .clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
  .regAddr(regAddr), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .busy(busy));
`default_nettype wire

// ==== sim/i2c_bus_master.sv ====
// Behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master #(
  parameter int LOW_NS  = 24,
  parameter int HIGH_NS = 8
) (
  // Bus lines
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  // Low phase stretched so the slave's data hold delay fits before the rise
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // SDA moves only with SCL low
  task automatic clockBit(input logic b, output logic r);
    sdaLow = !b;
    #(LOW_NS);
    scl = 1'b1;
    #(HIGH_NS);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic startCond();
    sdaLow = 1'b0;
    #(LOW_NS);
    scl = 1'b1;
    #(LOW_NS);
    sdaLow = 1'b1;
    #(LOW_NS);
    scl = 1'b0;
  endtask
  task automatic stopCond();
    sdaLow = 1'b1;
    #(LOW_NS);
    scl = 1'b1;
    #(LOW_NS);
    sdaLow = 1'b0;
    #(LOW_NS);
  endtask
  task automatic xferByte(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clockBit(d[i], r);
      q[i] = r;
    end
    clockBit(nine, r);
    ack = !r;
  endtask
endmodule
`default_nettype wire

// ==== sim/touch_i2c_slave_tb.sv ====
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_slave_tb;
  logic       clock;
  logic       rst;
  logic       scl;
  logic       sdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic [7:0] regAddr;
  logic [7:0] wrData;
  logic       wrStrobe;
  logic       rdStrobe;
  logic       busy;
  logic [7:0] mem [256];
  int         errors = 0;
  int         compares = 0;
  int         cycles = 0;
  int         wrCount = 0;
  int         rdCount = 0;
  wire        sda = !(sdaLow || sdaOe);

  i2c_bus_master bm (.scl(scl), .sdaLow(sdaLow), .sda(sda));
  touch_i2c_slave DUT (
    .clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .fixedLow(8'h10), .fixedHigh(8'h1F), .regAddr(regAddr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(mem[regAddr]), .busy(busy));

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (wrStrobe) begin
      mem[regAddr] <= wrData;
      wrCount++;
    end
    if (rdStrobe) begin
      rdCount++;
    end
    // Whole run is near 1950 cycles at the 32 ns link period
    if (cycles == 10000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] ackExp);
    logic [7:0] q;
    logic       a;
    bm.xferByte(b, 1'b1, q, a);
    chk("ack", ackExp, {7'h00, a});
  endtask
  task automatic recv(input logic nine, input logic [7:0] exp);
    logic [7:0] q;
    logic       a;
    bm.xferByte(8'hFF, nine, q, a);
    chk("rdByte", exp, q);
  endtask
  task automatic scForeign();
    send(8'h82, 8'h00);
    chk("busyNoStart", 8'h00, {7'h00, busy});
    chk("sdaOut", 8'h00, {7'h00, sdaOut});
    bm.startCond();
    send(8'h84, 8'h00);
    send(8'h12, 8'h00);
    bm.stopCond();
    chk("wrCount", 8'h00, 8'(wrCount));
  endtask
  task automatic scWriteWrap();
    bm.startCond();
    send(8'h82, 8'h01);
    send(8'hFE, 8'h01);
    send(8'hA5, 8'h01);
    send(8'h5A, 8'h01);
    send(8'hC3, 8'h01);
    bm.stopCond();
    chk("memFE", 8'hA5, mem[8'hFE]);
    chk("memFF", 8'h5A, mem[8'hFF]);
    chk("mem00", 8'hC3, mem[8'h00]);
    chk("busyStop", 8'h00, {7'h00, busy});
  endtask
  task automatic scWriteFixed();
    bm.startCond();
    send(8'h82, 8'h01);
    send(8'h12, 8'h01);
    send(8'h11, 8'h01);
    send(8'h22, 8'h01);
    bm.stopCond();
    chk("mem12", 8'h22, mem[8'h12]);
    chk("mem13", 8'h2F, mem[8'h13]);
  endtask
  task automatic scRead(input logic [7:0] ra, input logic [7:0] e0, input logic [7:0] e1);
    int rd0;
    rd0 = rdCount;
    bm.startCond();
    send(8'h82, 8'h01);
    send(ra, 8'h01);
    bm.startCond();
    send(8'h83, 8'h01);
    recv(1'b0, e0);
    recv(1'b1, e1);
    recv(1'b1, 8'hFF);
    bm.stopCond();
    chk("busyRd", 8'h00, {7'h00, busy});
    chk("rdCount", 8'h02, 8'(rdCount - rd0));
  endtask

  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    // Bus moves stay 1 ns after a clock edge, as all master delays are whole clocks
    #1;
    scForeign();
    scWriteWrap();
    scWriteFixed();
    // Wrap from the last register while reading
    scRead(8'hFF, 8'h5A, 8'hC3);
    scRead(8'h12, 8'h22, 8'h22);
    print_verdict();
  end
endmodule
`default_nettype wire
